// ### clfls_lpf.sv
// Shared package of the capacity flag and load model block, and the
// low-pass filter that smooths the average-current samples.
// Assumes one clock and samples that arrive as one-cycle strobes.

`timescale 1ns/1ps
`default_nettype none

package clfls_pkg;

    // Register byte offsets on the Wishbone bus
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_REMCAP = 8'h04;
    localparam logic [7:0] ADR_INIT_SET = 8'h08;
    localparam logic [7:0] ADR_INIT_CLR = 8'h0C;
    localparam logic [7:0] ADR_FINAL_SET = 8'h10;
    localparam logic [7:0] ADR_FINAL_CLR = 8'h14;
    localparam logic [7:0] ADR_AVGCUR = 8'h18;
    localparam logic [7:0] ADR_VOLTAGE = 8'h1C;
    localparam logic [7:0] ADR_HOST_AT_RATE_VALUE = 8'h20;
    localparam logic [7:0] ADR_USER_MA = 8'h24;
    localparam logic [7:0] ADR_USER_CW = 8'h28;
    localparam logic [7:0] ADR_DESIGN_CAP = 8'h2C;
    localparam logic [7:0] ADR_DESIGN_ENERGY = 8'h30;
    localparam logic [7:0] ADR_RESERVE_CWH = 8'h34;
    localparam logic [7:0] ADR_LAST_I = 8'h38;
    localparam logic [7:0] ADR_LAST_P = 8'h3C;
    localparam logic [7:0] ADR_STATUS = 8'h40;
    localparam logic [7:0] ADR_LOAD_RATE = 8'h44;
    localparam logic [7:0] ADR_USER_MW = 8'h48;
    localparam logic [7:0] ADR_RESERVE_MWH = 8'h4C;
    localparam logic [7:0] ADR_PRES_I = 8'h50;
    localparam logic [7:0] ADR_PRES_P = 8'h54;
    localparam logic [7:0] ADR_FILT_I = 8'h58;

    // Number of plain configuration words, offsets 0x00 to 0x34
    localparam int CFG_WORDS = 14;

    // Field positions
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_SEL_LSB = 4;
    localparam int STAT_INIT_BIT = 0;
    localparam int STAT_FINAL_BIT = 1;
    localparam int STAT_LOAD_MODEL_STATUS_BIT_BIT = 2;
    localparam int STAT_DSG_BIT = 3;

    // Reset values
    localparam logic RST_LOAD_MODE = 1'b0;
    localparam logic [2:0] RST_LOAD_SEL = 3'h1;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] THR_DISABLED = 16'hFFFF;

    // Timing: filter time constant against the sample period
    localparam int TAU_S = 14;
    localparam int SAMPLE_PERIOD_MS = 1000;
    localparam int LPF_SHIFT = $clog2(TAU_S * 1000 / SAMPLE_PERIOD_MS);
    localparam int LPF_FRAC = 8;
    localparam int MEAN_SHIFT_MAX = 8;

    // Scaling: uW to 10 mW units is x6711 >> 26, divide by five is
    // x13107 >> 16
    localparam logic signed [15:0] PWR_SCALE_MUL = 16'sh1A37;
    localparam int PWR_SCALE_SHIFT = 26;
    localparam logic [15:0] DIV5_MUL = 16'h3333;
    localparam int DIV5_SHIFT = 16;
    localparam logic [3:0] DISPLAY_MUL = 4'hA;

    typedef enum logic [2:0] {
        LS_LAST_RUN = 3'h0,
        LS_PRESENT = 3'h1,
        LS_AVERAGE = 3'h2,
        LS_FILTERED = 3'h3,
        LS_DESIGN_C5 = 3'h4,
        LS_AT_RATE = 3'h5,
        LS_USER_RATE = 3'h6
    } clfls_sel_type;

    typedef struct packed {
        logic loadMode;
        logic [2:0] loadSelect;
    } clfls_ctrl_type;

    typedef struct packed {
        logic initFlag;
        logic finalFlag;
        logic loadModeStatus;
    } clfls_flags_type;

endpackage : clfls_pkg

module clfls_lpf
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic sampleStb,
    input wire logic signed [15:0] sampleIn,
    output logic signed [15:0] filtOut
);
    logic signed [23:0] acc_reg;
    logic signed [23:0] acc_next;
    logic signed [23:0] diff;

    // First-order filter, one step per sample
    always_comb
    begin
        diff = 24'(sampleIn <<< clfls_pkg::LPF_FRAC) - acc_reg;
        acc_next = acc_reg;
        if (sampleStb)
        begin
            acc_next = acc_reg + (diff >>> clfls_pkg::LPF_SHIFT);
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            acc_reg <= 24'sh000000;
        end
        else
        begin
            acc_reg <= acc_next;
        end
    end

    assign filtOut = acc_reg[23:8];
endmodule : clfls_lpf

`default_nettype wire

// ### clfls_top.sv
// Capacity warning flags with hysteresis and load model rate selection,
// reached as a classic Wishbone slave with 32-bit data.
// Assumes the gauge core writes fresh samples over the bus.
//
// Functional notes
// - Set initial flag when remaining capacity falls below its set level.
// - Clear initial flag only when capacity rises above its clear level.
// - Set final flag when remaining capacity falls below final set level.
// - Final set level of minus one disables setting; compare signed.
// - Clear final flag only if set and capacity exceeds clear level.
// - Load mode 0 selects constant current (default), 1 constant power.
// - Load mode is mirrored into a readable status bit.
// - Current mode: 0 last-run average, 1 present discharge average.
// - Current mode: 2 average current, 3 filtered current, 14 s; the filter uses LPF_SHIFT 4, a 16-sample constant.
// - Current mode: 4 design capacity/5, 5 at-rate, 6 user rate mA.
// - Power mode: 0 last-run average power, 1 present average power.
// - Power mode: 2 average current times voltage, 3 filtered times V.
// - Power mode: 4 design energy/5, 5 at-rate, 6 user rate, 10 mW.
// - Power rate and reserve energy stored in 10 mW units, shown x10.
//
// Our own choices: the register offsets and register access over Wishbone.

`timescale 1ns/1ps
`default_nettype none

module clfls_top
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic initFlag,
    output logic finalFlag,
    output logic loadModeStatus,
    output logic signed [15:0] loadRate
);
    typedef enum logic [1:0] {
        DSG_IDLE = 2'b01,
        DSG_ACTIVE = 2'b10
    } clfls_dsg_type;

    ////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [15:0] mergeWord(input logic [15:0] old,
        input logic [31:0] wdat, input logic [3:0] sel);
        logic [15:0] res;
        res = old;
        if (sel[0])
            res[7:0] = wdat[7:0];
        if (sel[1])
            res[15:8] = wdat[15:8];
        return res;
    endfunction : mergeWord

    function automatic int meanShift(input logic [15:0] cnt);
        int s;
        s = 0;
        for (int i = 1; i <= clfls_pkg::MEAN_SHIFT_MAX; i++)
        begin
            if (cnt >= (16'h0001 << i))
                s = i;
        end
        return s;
    endfunction : meanShift

    function automatic logic signed [15:0] toTenMw(
        input logic signed [31:0] microWatt);
        logic signed [47:0] p;
        p = microWatt * clfls_pkg::PWR_SCALE_MUL;
        return 16'(p >>> clfls_pkg::PWR_SCALE_SHIFT);
    endfunction : toTenMw

    ////////////////////////////////////////////////////////////////////
    // State

    logic [15:0] cfg_reg [clfls_pkg::CFG_WORDS];
    logic [15:0] cfg_next [clfls_pkg::CFG_WORDS];
    logic signed [15:0] lastI_reg, lastI_next, lastP_reg, lastP_next;
    logic signed [15:0] presI_reg, presI_next, presP_reg, presP_next;
    logic [15:0] dsgCnt_reg, dsgCnt_next;
    clfls_dsg_type dsg_reg, dsg_next;
    clfls_pkg::clfls_flags_type flags_reg, flags_next;
    logic signed [15:0] loadRate_reg, loadRate_next;
    logic ack_reg, ack_next;
    logic [31:0] rdat_reg, rdat_next;
    logic remStb_reg, remStb_next, smpStb_reg, smpStb_next;

    logic access, wrAcc;
    logic [5:0] wordIdx;
    clfls_pkg::clfls_ctrl_type ctrl;
    logic signed [15:0] remCap, avgCur, filtCur;
    logic signed [31:0] pwrAvg, pwrFilt;
    logic signed [15:0] smpPwr;
    logic [31:0] div5;
    int shiftN;

    assign access = wb_cyc_i && wb_stb_i && !ack_reg;
    // A write lands at the edge that sees ack high, request still held
    assign wrAcc = wb_cyc_i && wb_stb_i && ack_reg && wb_we_i;
    assign wordIdx = wb_adr_i[7:2];
    assign ctrl.loadMode = cfg_reg[0][clfls_pkg::CTRL_MODE_BIT];
    assign ctrl.loadSelect = cfg_reg[0][clfls_pkg::CTRL_SEL_LSB +: 3];
    assign remCap = signed'(cfg_reg[1]);
    assign avgCur = signed'(cfg_reg[6]);

    clfls_lpf u_lpf
    (
        .mclk(mclk),
        .rst(rst),
        .sampleStb(smpStb_reg),
        .sampleIn(avgCur),
        .filtOut(filtCur)
    );

    ////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb
    begin
        cfg_next = cfg_reg;
        lastI_next = lastI_reg;
        lastP_next = lastP_reg;
        presI_next = presI_reg;
        presP_next = presP_reg;
        dsgCnt_next = dsgCnt_reg;
        dsg_next = dsg_reg;
        flags_next = flags_reg;
        loadRate_next = loadRate_reg;
        rdat_next = rdat_reg;
        ack_next = access;
        remStb_next = 1'b0;
        smpStb_next = 1'b0;
        pwrAvg = avgCur * signed'({1'b0, cfg_reg[7]});
        pwrFilt = filtCur * signed'({1'b0, cfg_reg[7]});
        smpPwr = toTenMw(pwrAvg);
        shiftN = meanShift(dsgCnt_reg);
        div5 = 32'h00000000;

        // Bus writes; a sample strobe follows a write by one cycle
        if (wrAcc && wordIdx < 6'(clfls_pkg::CFG_WORDS))
        begin
            cfg_next[wordIdx[3:0]] =
                mergeWord(cfg_reg[wordIdx[3:0]], wb_dat_i, wb_sel_i);
            remStb_next = (wb_adr_i == clfls_pkg::ADR_REMCAP);
            smpStb_next = (wb_adr_i == clfls_pkg::ADR_AVGCUR);
        end
        if (wrAcc && wb_adr_i == clfls_pkg::ADR_LAST_I)
            lastI_next = signed'(mergeWord(lastI_reg, wb_dat_i, wb_sel_i));
        if (wrAcc && wb_adr_i == clfls_pkg::ADR_LAST_P)
            lastP_next = signed'(mergeWord(lastP_reg, wb_dat_i, wb_sel_i));

        // Warning flags, evaluated once per new capacity value
        if (remStb_reg)
        begin
            if (remCap > signed'(cfg_reg[3]))
                flags_next.initFlag = 1'b0;
            if (remCap < signed'(cfg_reg[2]))
                flags_next.initFlag = 1'b1;
            if (flags_reg.finalFlag && remCap > signed'(cfg_reg[5]))
                flags_next.finalFlag = 1'b0;
            if (cfg_reg[4] != clfls_pkg::THR_DISABLED
                && remCap < signed'(cfg_reg[4]))
                flags_next.finalFlag = 1'b1;
        end
        flags_next.loadModeStatus = ctrl.loadMode;

        // Discharge tracking: running means, last-run capture at the end
        if (smpStb_reg)
        begin
            case (dsg_reg)
                DSG_IDLE:
                begin
                    if (avgCur < 16'sh0000)
                    begin
                        dsg_next = DSG_ACTIVE;
                        dsgCnt_next = 16'h0001;
                        presI_next = avgCur;
                        presP_next = smpPwr;
                    end
                end
                DSG_ACTIVE:
                begin
                    if (avgCur < 16'sh0000)
                    begin
                        if (dsgCnt_reg != 16'hFFFF)
                            dsgCnt_next = dsgCnt_reg + 16'h0001;
                        presI_next = presI_reg + 16'(
                            (17'(avgCur) - 17'(presI_reg)) >>> shiftN);
                        presP_next = presP_reg + 16'(
                            (17'(smpPwr) - 17'(presP_reg)) >>> shiftN);
                    end
                    else
                    begin
                        dsg_next = DSG_IDLE;
                        lastI_next = presI_reg;
                        lastP_next = presP_reg;
                    end
                end
                default:
                begin
                    dsg_next = DSG_IDLE;
                end
            endcase
        end

        // Load model rate selection
        if (!ctrl.loadMode)
        begin
            div5 = 32'(cfg_reg[11] * clfls_pkg::DIV5_MUL);
            case (clfls_pkg::clfls_sel_type'(ctrl.loadSelect))
                clfls_pkg::LS_LAST_RUN: loadRate_next = lastI_reg;
                clfls_pkg::LS_PRESENT: loadRate_next = presI_reg;
                clfls_pkg::LS_AVERAGE: loadRate_next = avgCur;
                clfls_pkg::LS_FILTERED: loadRate_next = filtCur;
                clfls_pkg::LS_DESIGN_C5:
                    loadRate_next = signed'(div5[31:16]);
                clfls_pkg::LS_AT_RATE:
                    loadRate_next = signed'(cfg_reg[8]);
                clfls_pkg::LS_USER_RATE:
                    loadRate_next = signed'(cfg_reg[9]);
                default: loadRate_next = loadRate_reg;
            endcase
        end
        else
        begin
            div5 = 32'(cfg_reg[12] * clfls_pkg::DIV5_MUL);
            case (clfls_pkg::clfls_sel_type'(ctrl.loadSelect))
                clfls_pkg::LS_LAST_RUN: loadRate_next = lastP_reg;
                clfls_pkg::LS_PRESENT: loadRate_next = presP_reg;
                clfls_pkg::LS_AVERAGE:
                    loadRate_next = toTenMw(pwrAvg);
                clfls_pkg::LS_FILTERED:
                    loadRate_next = toTenMw(pwrFilt);
                clfls_pkg::LS_DESIGN_C5:
                    loadRate_next = signed'(div5[31:16]);
                clfls_pkg::LS_AT_RATE:
                    loadRate_next = signed'(cfg_reg[8]);
                clfls_pkg::LS_USER_RATE:
                    loadRate_next = signed'(cfg_reg[10]);
                default: loadRate_next = loadRate_reg;
            endcase
        end

        // Read data; unmapped addresses read zero
        if (access && !wb_we_i)
        begin
            rdat_next = 32'h00000000;
            if (wordIdx < 6'(clfls_pkg::CFG_WORDS))
                rdat_next = {16'h0000, cfg_reg[wordIdx[3:0]]};
            case (wb_adr_i)
                clfls_pkg::ADR_LAST_I: rdat_next = 32'(lastI_reg);
                clfls_pkg::ADR_LAST_P: rdat_next = 32'(lastP_reg);
                clfls_pkg::ADR_STATUS:
                begin
                    rdat_next[clfls_pkg::STAT_INIT_BIT] = flags_reg.initFlag;
                    rdat_next[clfls_pkg::STAT_FINAL_BIT] =
                        flags_reg.finalFlag;
                    rdat_next[clfls_pkg::STAT_LOAD_MODEL_STATUS_BIT_BIT] =
                        flags_reg.loadModeStatus;
                    rdat_next[clfls_pkg::STAT_DSG_BIT] =
                        (dsg_reg == DSG_ACTIVE);
                end
                clfls_pkg::ADR_LOAD_RATE: rdat_next = 32'(loadRate_reg);
                clfls_pkg::ADR_USER_MW:
                    rdat_next = 32'(signed'(cfg_reg[10])
                        * signed'({1'b0, clfls_pkg::DISPLAY_MUL}));
                clfls_pkg::ADR_RESERVE_MWH:
                    rdat_next = 32'(signed'(cfg_reg[13])
                        * signed'({1'b0, clfls_pkg::DISPLAY_MUL}));
                clfls_pkg::ADR_PRES_I: rdat_next = 32'(presI_reg);
                clfls_pkg::ADR_PRES_P: rdat_next = 32'(presP_reg);
                clfls_pkg::ADR_FILT_I: rdat_next = 32'(filtCur);
                default: rdat_next = rdat_next;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < clfls_pkg::CFG_WORDS; i++)
                cfg_reg[i] <= clfls_pkg::RST_WORD;
            cfg_reg[0][clfls_pkg::CTRL_MODE_BIT] <= clfls_pkg::RST_LOAD_MODE;
            cfg_reg[0][clfls_pkg::CTRL_SEL_LSB +: 3] <=
                clfls_pkg::RST_LOAD_SEL;
            lastI_reg <= 16'sh0000;
            lastP_reg <= 16'sh0000;
            presI_reg <= 16'sh0000;
            presP_reg <= 16'sh0000;
            dsgCnt_reg <= 16'h0000;
            dsg_reg <= DSG_IDLE;
            flags_reg <= '0;
            loadRate_reg <= 16'sh0000;
            ack_reg <= 1'b0;
            rdat_reg <= 32'h00000000;
            remStb_reg <= 1'b0;
            smpStb_reg <= 1'b0;
        end
        else
        begin
            cfg_reg <= cfg_next;
            lastI_reg <= lastI_next;
            lastP_reg <= lastP_next;
            presI_reg <= presI_next;
            presP_reg <= presP_next;
            dsgCnt_reg <= dsgCnt_next;
            dsg_reg <= dsg_next;
            flags_reg <= flags_next;
            loadRate_reg <= loadRate_next;
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
            remStb_reg <= remStb_next;
            smpStb_reg <= smpStb_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;
    assign initFlag = flags_reg.initFlag;
    assign finalFlag = flags_reg.finalFlag;
    assign loadModeStatus = flags_reg.loadModeStatus;
    assign loadRate = loadRate_reg;
endmodule : clfls_top

`default_nettype wire

// ### clfls_checker.sv
// Checker of the capacity flag block: bus timing, flag hysteresis and
// the load mode mirror. Sees only the top ports; assumes full-word writes.
`timescale 1ns/1ps
`default_nettype none

module clfls_checker
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic initFlag,
    input wire logic finalFlag,
    input wire logic loadModeStatus,
    input wire logic signed [15:0] loadRate
);
    logic signed [15:0] initSet, initClr, finalSet, finalClr, remVal;
    logic take, wrDone, remWr, ctrlWr, finalArmed;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // Writes land at the edge that samples ack high
    assign wrDone = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
    assign remWr = wrDone && wb_adr_i == clfls_pkg::ADR_REMCAP;
    assign ctrlWr = wrDone && wb_adr_i == clfls_pkg::ADR_CTRL;
    assign remVal = wb_dat_i[15:0];
    assign finalArmed = finalSet != clfls_pkg::THR_DISABLED
        && remVal < finalSet;

    // Shadow copies of the thresholds, taken as a write lands
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            initSet <= '0;
            initClr <= '0;
            finalSet <= '0;
            finalClr <= '0;
        end
        else if (wrDone)
        begin
            case (wb_adr_i)
                clfls_pkg::ADR_INIT_SET: initSet <= wb_dat_i[15:0];
                clfls_pkg::ADR_INIT_CLR: initClr <= wb_dat_i[15:0];
                clfls_pkg::ADR_FINAL_SET: finalSet <= wb_dat_i[15:0];
                clfls_pkg::ADR_FINAL_CLR: finalClr <= wb_dat_i[15:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    ack_timing_a: assert property (take |=> wb_ack_o)
        else $error("bus request not answered after one cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus answer longer than one cycle");
    unmapped_read_a: assert property (take && !wb_we_i && wb_adr_i == 8'hFC
        |=> wb_dat_o == 32'h00000000) else $error("unmapped read not zero");
    init_set_a: assert property (
        remWr && remVal < initSet |=> ##1 initFlag)
        else $error("initial flag not set below its level");
    init_clear_a: assert property (
        remWr && remVal > initClr && !(remVal < initSet) |=> ##1 !initFlag)
        else $error("initial flag not cleared above its level");
    final_set_a: assert property (
        remWr && finalArmed |=> ##1 finalFlag)
        else $error("final flag not set below its level");
    final_off_a: assert property (
        remWr && finalSet == clfls_pkg::THR_DISABLED && !finalFlag
        |=> ##1 !finalFlag) else $error("disabled final flag was set");
    final_clear_a: assert property (
        remWr && finalFlag && remVal > finalClr && !finalArmed
        |=> ##1 !finalFlag) else $error("final flag not cleared");
    init_hold_a: assert property (
        $changed(initFlag) |-> $past(remWr, 2))
        else $error("initial flag moved without a capacity value");
    final_hold_a: assert property (
        $changed(finalFlag) |-> $past(remWr, 2))
        else $error("final flag moved without a capacity value");
    load_model_status_bit_follow_a: assert property (
        ctrlWr && wb_sel_i[0] |=> ##1 loadModeStatus == $past(wb_dat_i[0], 2))
        else $error("mode status does not follow the mode setting");
    stat_read_a: assert property (
        take && !wb_we_i && wb_adr_i == clfls_pkg::ADR_STATUS |=> wb_dat_o[2:0]
        == {$past(loadModeStatus), $past(finalFlag), $past(initFlag)})
        else $error("status word differs from the flag outputs");

    cover property (remWr && remVal < initSet);
    cover property ($rose(finalFlag));
    cover property ($fell(initFlag));
    cover property ($rose(loadModeStatus));
endmodule : clfls_checker
`default_nettype wire

// ### clfls_tb_top.sv
// Self-checking bench of the capacity flag block over classic Wishbone.
// Assumes the design files and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none

module clfls_tb_top;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic ack, initFlag, finalFlag, loadModeStatus;
    logic signed [15:0] loadRate;
    int miscompares = 0;
    int comparisons = 0;
    // Capacity steps and the expected {initial, final} flags after each
    localparam logic [15:0] REM_SEQ [7] = '{16'h0096, 16'h0063, 16'h0031,
        16'h0037, 16'h003D, 16'h00C8, 16'h00C9};
    localparam logic [1:0] FLAG_SEQ [7] = '{2'h0, 2'h2, 2'h3, 2'h3, 2'h2,
        2'h2, 2'h0};
    localparam logic [7:0] CFG_ADR [10] = '{8'h18, 8'h1C, 8'h20, 8'h24,
        8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C};
    localparam logic [15:0] CFG_DAT [10] = '{16'h03E8, 16'h0FA0, 16'h0123,
        16'h0234, 16'h0345, 16'h01F4, 16'h03E8, 16'h0056, 16'hFED4, 16'hFB95};
    localparam logic [15:0] CTRL_TAB [13] = '{16'h0000, 16'h0020, 16'h0040,
        16'h0050, 16'h0060, 16'h0001, 16'h0021, 16'h0041, 16'h0051, 16'h0061,
        16'h0030, 16'h0031, 16'h0071};
    // 1000 mA x 4000 mV is 400 in 10 mW; 500 and 1000 through x13107>>16;
    // one filter step of 1000 mA gives 62; selector 7 holds the last rate
    localparam logic [15:0] RATE_TAB [13] = '{16'hFED4, 16'h03E8, 16'h0063,
        16'h0123, 16'h0234, 16'hFB95, 16'h0190, 16'h00C7, 16'h0123, 16'h0345,
        16'h003E, 16'h0018, 16'h0018};

    always #12.5 mclk = ~mclk;

    clfls_top u_clfls_top (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .initFlag(initFlag), .finalFlag(finalFlag),
        .loadModeStatus(loadModeStatus), .loadRate(loadRate));

    function automatic logic [31:0] sx(input logic [15:0] v);
        return {{16{v[15]}}, v};
    endfunction : sx

    task automatic summarize();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize

    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        comparisons++;
        if (seen !== expd)
        begin
            miscompares++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, expd);
        end
    endtask : check

    task automatic wbAccess(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        adr <= a;
        sel <= 4'hF;
        wdat <= d;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (ack !== 1'b1)
        begin
            miscompares++;
            $display("unexpected at %0t: no bus answer", $time);
            summarize();
        end
    endtask : wbAccess

    task automatic wbWrite(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] q;
        wbAccess(1'b1, a, {16'h0000, d}, q);
    endtask : wbWrite

    task automatic readCheck(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wbAccess(1'b0, a, 32'h00000000, q);
        check(q, e);
    endtask : readCheck

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        check({29'h0, loadModeStatus, finalFlag, initFlag}, 32'h0);
        readCheck(clfls_pkg::ADR_CTRL, 32'h00000010);
        readCheck(8'hFC, 32'h00000000);
        $display("test defaults done");

        wbWrite(clfls_pkg::ADR_INIT_SET, 16'h0064);
        wbWrite(clfls_pkg::ADR_INIT_CLR, 16'h00C8);
        wbWrite(clfls_pkg::ADR_FINAL_SET, 16'h0032);
        wbWrite(clfls_pkg::ADR_FINAL_CLR, 16'h003C);
        for (int i = 0; i < 7; i++)
        begin
            wbWrite(clfls_pkg::ADR_REMCAP, REM_SEQ[i]);
            repeat (2) @(negedge mclk);
            check({30'h0, initFlag, finalFlag}, {30'h0, FLAG_SEQ[i]});
            readCheck(clfls_pkg::ADR_STATUS, {30'h0, FLAG_SEQ[i][0], FLAG_SEQ[i][1]});
        end
        wbWrite(clfls_pkg::ADR_FINAL_SET, 16'hFFFF);
        wbWrite(clfls_pkg::ADR_REMCAP, 16'hFF00);
        repeat (2) @(negedge mclk);
        check({30'h0, initFlag, finalFlag}, 32'h00000002);
        $display("test flags done");

        for (int i = 0; i < 10; i++)
            wbWrite(CFG_ADR[i], CFG_DAT[i]);
        for (int i = 0; i < 13; i++)
        begin
            wbWrite(clfls_pkg::ADR_CTRL, CTRL_TAB[i]);
            repeat (2) @(negedge mclk);
            check(sx(loadRate), sx(RATE_TAB[i]));
            check({31'h0, loadModeStatus}, {31'h0, CTRL_TAB[i][0]});
            readCheck(clfls_pkg::ADR_LOAD_RATE, sx(RATE_TAB[i]));
            readCheck(clfls_pkg::ADR_STATUS, {29'h0, CTRL_TAB[i][0], 2'h1});
        end
        $display("test load model done");

        readCheck(clfls_pkg::ADR_USER_MW, sx(16'h20B2));
        readCheck(clfls_pkg::ADR_RESERVE_MWH, sx(16'h035C));
        $display("test display scaling done");

        wbWrite(clfls_pkg::ADR_AVGCUR, 16'hFF38);
        wbWrite(clfls_pkg::ADR_CTRL, 16'h0010);
        repeat (2) @(negedge mclk);
        check(sx(loadRate), sx(16'hFF38));
        readCheck(clfls_pkg::ADR_STATUS, 32'h00000009);
        wbWrite(clfls_pkg::ADR_AVGCUR, 16'h0000);
        wbWrite(clfls_pkg::ADR_CTRL, 16'h0000);
        repeat (2) @(negedge mclk);
        check(sx(loadRate), sx(16'hFF38));
        $display("test discharge averages done");
        summarize();
    end
endmodule : clfls_tb_top

bind clfls_top clfls_checker u_clfls_checker (.mclk(mclk), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .initFlag(initFlag),
    .finalFlag(finalFlag), .loadModeStatus(loadModeStatus),
    .loadRate(loadRate));
`default_nettype wire
